// ### src/csio_pkg.sv
package csio_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_AW = 5;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned IO_AW = 6;
  localparam int unsigned BIT_AW = 3;

  // I/O space map
  localparam logic [5:0] IO_FLAGS_ADDR = 6'h3F;
  localparam logic [5:0] IO_BIT_LAST = 6'h1F;

  // Status flag bit positions
  localparam int unsigned FLG_I = 7;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_C = 0;

  // Nibble and sign bit positions inside a data byte
  localparam int unsigned NIB_MSB = 3;
  localparam int unsigned BYTE_MSB = 7;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;

  typedef enum logic [4:0] {
    CSIO_OP_NOP = 5'h00,
    CSIO_OP_ADD = 5'h01,
    CSIO_OP_ADC = 5'h02,
    CSIO_OP_SUB = 5'h03,
    CSIO_OP_SBC = 5'h04,
    CSIO_OP_AND = 5'h05,
    CSIO_OP_OR = 5'h06,
    CSIO_OP_EOR = 5'h07,
    CSIO_OP_MOV = 5'h08,
    CSIO_OP_LDI = 5'h09,
    CSIO_OP_IN = 5'h0A,
    CSIO_OP_OUT = 5'h0B,
    CSIO_OP_IO_BIT_SET = 5'h0C,
    CSIO_OP_IO_BIT_CLEAR = 5'h0D,
    CSIO_OP_SKIP_IO_ONE = 5'h0E,
    CSIO_OP_SKIP_IO_ZERO = 5'h0F,
    CSIO_OP_BIT_STORE = 5'h10,
    CSIO_OP_BIT_LOAD = 5'h11,
    CSIO_OP_RETURN_HANDLER = 5'h12
  } csio_op_t;

endpackage

// ### src/csio_regfile.sv
`timescale 1ns/1ps
`default_nettype none

module csio_regfile (
  input wire logic clk,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data
);

  logic [7:0] mem_q [csio_pkg::REG_COUNT];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Write-first bypass lets a dependent op issue right behind its producer
  always_ff @(posedge clk) begin
    if (wr_en && (wr_addr == rd_addr_a)) begin
      rd_data_a <= wr_data;
    end else begin
      rd_data_a <= mem_q[rd_addr_a];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && (wr_addr == rd_addr_b)) begin
      rd_data_b <= wr_data;
    end else begin
      rd_data_b <= mem_q[rd_addr_b];
    end
  end

endmodule

`default_nettype wire

// ### src/csio_core.sv
// Operation
// [RULE1] Flag bit 7 enables interrupts globally; while clear none is taken.
// [RULE2] Taking an interrupt clears bit 7; return from handler sets it again.
// [RULE3] Bit 6 is a copy bit: bit store fills it, bit load reads it.
// [RULE4] Bit 5 holds the low-nibble carry of arithmetic that updates it.
// [RULE5] Bit 4 always equals negative flag xor overflow flag.
// [RULE6] Bit 3 holds two's complement overflow of updating arithmetic.
// [RULE7] Bit 2 is set for a negative result, cleared otherwise.
// [RULE8] Bit 1 is set for a zero result, cleared otherwise. Here subtract with carry sets it only if it was already set.
// [RULE9] Bit 0 holds the carry of an updating operation.
// [RULE10] Interrupt entry and return never save or restore the flags.
// [RULE11] The flag register sits at I/O location 0x3F.
// [RULE12] I/O load and store move bytes between 32 working registers and I/O.
// [RULE13] Bit set, clear and skip tests act on I/O 0x00 to 0x1F only.
// [RULE14] Bit set or clear rewrites the whole byte, clearing write-one flags.
// [RULE15] Software writes reserved bits as zero and never writes reserved addresses.
// [RULE16] One cycle reads two operands, runs the ALU and writes the result.
// [RULE17] The core runs on the undivided system clock.
// [RULE18] All flag bits, interrupt enable included, are zero after reset.
`timescale 1ns/1ps
`default_nettype none

module csio_core (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic OP_VALID,
  input wire logic [4:0] OP_CODE,
  input wire logic [4:0] OP_DST,
  input wire logic [4:0] OP_SRC,
  input wire logic [7:0] OP_IMM,
  input wire logic [5:0] OP_IO,
  input wire logic [2:0] OP_BIT,
  input wire logic IRQ_REQ,
  input wire logic [7:0] IO_RDATA,
  output logic [7:0] FLAGS,
  output logic [7:0] RESULT,
  output logic RESULT_VALID,
  output logic SKIP,
  output logic IRQ_TAKEN,
  output logic [5:0] IO_ADDR,
  output logic IO_RD,
  output logic [5:0] IO_WADDR,
  output logic [7:0] IO_WDATA,
  output logic IO_WR
);

  // Flags after an add; carries are recovered from operand and result bits
  function automatic logic [7:0] add_flags(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] r,
    input logic [7:0] old
  );
    logic [7:0] f;
    f = old;
    f[csio_pkg::FLG_H] = (a[csio_pkg::NIB_MSB] & b[csio_pkg::NIB_MSB]) |
                         (b[csio_pkg::NIB_MSB] & ~r[csio_pkg::NIB_MSB]) |
                         (~r[csio_pkg::NIB_MSB] & a[csio_pkg::NIB_MSB]);
    f[csio_pkg::FLG_V] = (a[csio_pkg::BYTE_MSB] & b[csio_pkg::BYTE_MSB] & ~r[csio_pkg::BYTE_MSB]) |
                         (~a[csio_pkg::BYTE_MSB] & ~b[csio_pkg::BYTE_MSB] & r[csio_pkg::BYTE_MSB]);
    f[csio_pkg::FLG_C] = (a[csio_pkg::BYTE_MSB] & b[csio_pkg::BYTE_MSB]) |
                         (b[csio_pkg::BYTE_MSB] & ~r[csio_pkg::BYTE_MSB]) |
                         (~r[csio_pkg::BYTE_MSB] & a[csio_pkg::BYTE_MSB]);
    f[csio_pkg::FLG_N] = r[csio_pkg::BYTE_MSB];
    f[csio_pkg::FLG_Z] = (r == csio_pkg::BYTE_ZERO);
    return f;
  endfunction

  // Flags after a subtract; borrow sits in the carry bit
  function automatic logic [7:0] sub_flags(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] r,
    input logic [7:0] old
  );
    logic [7:0] f;
    f = old;
    f[csio_pkg::FLG_H] = (~a[csio_pkg::NIB_MSB] & b[csio_pkg::NIB_MSB]) |
                         (b[csio_pkg::NIB_MSB] & r[csio_pkg::NIB_MSB]) |
                         (r[csio_pkg::NIB_MSB] & ~a[csio_pkg::NIB_MSB]);
    f[csio_pkg::FLG_V] = (a[csio_pkg::BYTE_MSB] & ~b[csio_pkg::BYTE_MSB] & ~r[csio_pkg::BYTE_MSB]) |
                         (~a[csio_pkg::BYTE_MSB] & b[csio_pkg::BYTE_MSB] & r[csio_pkg::BYTE_MSB]);
    f[csio_pkg::FLG_C] = (~a[csio_pkg::BYTE_MSB] & b[csio_pkg::BYTE_MSB]) |
                         (b[csio_pkg::BYTE_MSB] & r[csio_pkg::BYTE_MSB]) |
                         (r[csio_pkg::BYTE_MSB] & ~a[csio_pkg::BYTE_MSB]);
    f[csio_pkg::FLG_N] = r[csio_pkg::BYTE_MSB];
    f[csio_pkg::FLG_Z] = (r == csio_pkg::BYTE_ZERO);
    return f;
  endfunction

  // Logic ops clear overflow and leave carry and half carry alone
  function automatic logic [7:0] logic_flags(
    input logic [7:0] r,
    input logic [7:0] old
  );
    logic [7:0] f;
    f = old;
    f[csio_pkg::FLG_V] = 1'b0;
    f[csio_pkg::FLG_N] = r[csio_pkg::BYTE_MSB];
    f[csio_pkg::FLG_Z] = (r == csio_pkg::BYTE_ZERO);
    return f;
  endfunction

  function automatic logic bit_addressable(input logic [5:0] io);
    return io <= csio_pkg::IO_BIT_LAST;
  endfunction

  // Ops that must sample an outside I/O register while they execute
  function automatic logic reads_outside_io(
    input csio_pkg::csio_op_t op,
    input logic [5:0] io
  );
    logic r;
    r = 1'b0;
    case (op)
      csio_pkg::CSIO_OP_IN: r = (io != csio_pkg::IO_FLAGS_ADDR);
      csio_pkg::CSIO_OP_IO_BIT_SET,
      csio_pkg::CSIO_OP_IO_BIT_CLEAR,
      csio_pkg::CSIO_OP_SKIP_IO_ONE,
      csio_pkg::CSIO_OP_SKIP_IO_ZERO: r = bit_addressable(io);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  csio_pkg::csio_op_t issue_op;
  csio_pkg::csio_op_t ex_op_q;
  logic ex_valid_q;
  logic [4:0] ex_dst_q;
  logic [7:0] ex_imm_q;
  logic [5:0] ex_io_q;
  logic [2:0] ex_bit_q;
  logic ex_rd_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] opnd_a;
  logic [7:0] opnd_b;
  logic [7:0] alu_res;
  logic alu_wb;
  logic io_wr_d;
  logic [7:0] io_wdata_d;
  logic skip_d;
  logic irq_take;
  logic [7:0] bit_mask;
  logic [7:0] result_q;
  logic result_valid_q;
  logic skip_q;
  logic irq_taken_q;
  logic [5:0] io_waddr_q;
  logic [7:0] io_wdata_q;
  logic io_wr_q;

  assign issue_op = csio_pkg::csio_op_t'(OP_CODE);
  assign bit_mask = csio_pkg::BIT_ONE << ex_bit_q;

  // Operands are read at issue so that execute sees both in the same cycle
  csio_regfile u_regfile (
    .clk(REF_CLK),
    .rd_addr_a(OP_DST),
    .rd_addr_b(OP_SRC),
    .rd_data_a(opnd_a),
    .rd_data_b(opnd_b),
    .wr_en(alu_wb),
    .wr_addr(ex_dst_q),
    .wr_data(alu_res)
  );

  // Issue stage; no divider anywhere, every stage advances on each edge
  always_ff @(posedge REF_CLK) begin // [RULE17]
    if (SRST) begin
      ex_valid_q <= 1'b0;
      ex_op_q <= csio_pkg::CSIO_OP_NOP;
      ex_dst_q <= '0;
      ex_imm_q <= csio_pkg::BYTE_ZERO;
      ex_io_q <= '0;
      ex_bit_q <= '0;
      ex_rd_q <= 1'b0;
    end else begin
      ex_valid_q <= OP_VALID;
      ex_op_q <= OP_VALID ? issue_op : csio_pkg::CSIO_OP_NOP;
      ex_dst_q <= OP_DST;
      ex_imm_q <= OP_IMM;
      ex_io_q <= OP_IO;
      ex_bit_q <= OP_BIT;
      ex_rd_q <= OP_VALID && reads_outside_io(issue_op, OP_IO);
    end
  end

  // Interrupt acceptance is gated only by the global enable
  assign irq_take = IRQ_REQ && flags_q[csio_pkg::FLG_I]; // [RULE1]

  // Execute stage: operands in, ALU, result and flags out in one cycle
  always_comb begin // [RULE16]
    flags_d = flags_q;
    alu_res = csio_pkg::BYTE_ZERO;
    alu_wb = 1'b0;
    io_wr_d = 1'b0;
    io_wdata_d = opnd_a;
    skip_d = 1'b0;
    case (ex_op_q)
      csio_pkg::CSIO_OP_ADD: begin
        alu_res = opnd_a + opnd_b;
        flags_d = add_flags(opnd_a, opnd_b, alu_res, flags_q); // [RULE4] [RULE6] [RULE7] [RULE8] [RULE9]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_ADC: begin
        alu_res = opnd_a + opnd_b + {7'h00, flags_q[csio_pkg::FLG_C]};
        flags_d = add_flags(opnd_a, opnd_b, alu_res, flags_q); // [RULE4] [RULE9]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_SUB: begin
        alu_res = opnd_a - opnd_b;
        flags_d = sub_flags(opnd_a, opnd_b, alu_res, flags_q); // [RULE4] [RULE6] [RULE9]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_SBC: begin
        alu_res = opnd_a - opnd_b - {7'h00, flags_q[csio_pkg::FLG_C]};
        flags_d = sub_flags(opnd_a, opnd_b, alu_res, flags_q); // [RULE4] [RULE6] [RULE9]
        // Zero can only survive a chained subtract, so multi-byte compares work
        flags_d[csio_pkg::FLG_Z] = flags_d[csio_pkg::FLG_Z] & flags_q[csio_pkg::FLG_Z]; // [RULE8]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_AND: begin
        alu_res = opnd_a & opnd_b;
        flags_d = logic_flags(alu_res, flags_q); // [RULE7] [RULE8]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_OR: begin
        alu_res = opnd_a | opnd_b;
        flags_d = logic_flags(alu_res, flags_q); // [RULE7] [RULE8]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_EOR: begin
        alu_res = opnd_a ^ opnd_b;
        flags_d = logic_flags(alu_res, flags_q); // [RULE7] [RULE8]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_MOV: begin
        alu_res = opnd_b;
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_LDI: begin
        alu_res = ex_imm_q;
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_IN: begin
        // The flag register is served locally, all else from outside
        alu_res = (ex_io_q == csio_pkg::IO_FLAGS_ADDR) ? flags_q : IO_RDATA; // [RULE11] [RULE12]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_OUT: begin
        if (ex_io_q == csio_pkg::IO_FLAGS_ADDR) begin
          flags_d = opnd_a; // [RULE11]
        end else begin
          io_wr_d = 1'b1; // [RULE12]
        end
      end
      csio_pkg::CSIO_OP_IO_BIT_SET: begin
        // Whole byte goes back, so write-one flags read as set get cleared
        io_wdata_d = IO_RDATA | bit_mask; // [RULE14]
        io_wr_d = bit_addressable(ex_io_q); // [RULE13]
      end
      csio_pkg::CSIO_OP_IO_BIT_CLEAR: begin
        io_wdata_d = IO_RDATA & ~bit_mask; // [RULE14]
        io_wr_d = bit_addressable(ex_io_q); // [RULE13]
      end
      csio_pkg::CSIO_OP_SKIP_IO_ONE: begin
        skip_d = bit_addressable(ex_io_q) && IO_RDATA[ex_bit_q]; // [RULE13]
      end
      csio_pkg::CSIO_OP_SKIP_IO_ZERO: begin
        skip_d = bit_addressable(ex_io_q) && !IO_RDATA[ex_bit_q]; // [RULE13]
      end
      csio_pkg::CSIO_OP_BIT_STORE: begin
        flags_d[csio_pkg::FLG_T] = opnd_a[ex_bit_q]; // [RULE3]
      end
      csio_pkg::CSIO_OP_BIT_LOAD: begin
        alu_res = opnd_a;
        alu_res[ex_bit_q] = flags_q[csio_pkg::FLG_T]; // [RULE3]
        alu_wb = 1'b1;
      end
      csio_pkg::CSIO_OP_RETURN_HANDLER: begin
        // Only the enable comes back; the other flags are software's job
        flags_d[csio_pkg::FLG_I] = 1'b1; // [RULE2] [RULE10]
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
    // Clear beats any same-cycle set so a second interrupt cannot slip in
    if (irq_take) begin
      flags_d[csio_pkg::FLG_I] = 1'b0; // [RULE2]
    end
    // Sign is derived, even on a direct store into the flag register
    flags_d[csio_pkg::FLG_S] = flags_d[csio_pkg::FLG_N] ^ flags_d[csio_pkg::FLG_V]; // [RULE5]
  end

  // Interrupt entry touches the enable only, no flag image is kept
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      flags_q <= csio_pkg::FLAGS_RST; // [RULE18]
    end else begin
      flags_q <= flags_d; // [RULE10]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      result_q <= csio_pkg::BYTE_ZERO;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= alu_wb;
      if (alu_wb) begin
        result_q <= alu_res;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      skip_q <= 1'b0;
      irq_taken_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
      irq_taken_q <= irq_take; // [RULE2]
    end
  end

  // Outside writes land one cycle after execute; a read right behind
  // a write to the same outside register sees the old value
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      io_wr_q <= 1'b0;
      io_waddr_q <= '0;
      io_wdata_q <= csio_pkg::BYTE_ZERO;
    end else begin
      io_wr_q <= io_wr_d;
      if (io_wr_d) begin
        io_waddr_q <= ex_io_q;
        io_wdata_q <= io_wdata_d;
      end
    end
  end

  assign FLAGS = flags_q;
  assign RESULT = result_q;
  assign RESULT_VALID = result_valid_q;
  assign SKIP = skip_q;
  assign IRQ_TAKEN = irq_taken_q;
  assign IO_ADDR = ex_io_q;
  assign IO_RD = ex_rd_q;
  assign IO_WADDR = io_waddr_q;
  assign IO_WDATA = io_wdata_q;
  assign IO_WR = io_wr_q;

endmodule

`default_nettype wire

// ### tb/csio_checker.sv
`timescale 1ns/1ps
`default_nettype none

module csio_checker (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic OP_VALID,
  input wire logic [4:0] OP_CODE,
  input wire logic [5:0] OP_IO,
  input wire logic [2:0] OP_BIT,
  input wire logic IRQ_REQ,
  input wire logic [7:0] IO_RDATA,
  input wire logic [7:0] FLAGS,
  input wire logic RESULT_VALID,
  input wire logic SKIP,
  input wire logic IRQ_TAKEN,
  input wire logic [5:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic [5:0] IO_WADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  logic bit_op;
  logic flag_io;
  assign bit_op = OP_VALID && OP_CODE >= csio_pkg::CSIO_OP_IO_BIT_SET && OP_CODE <= csio_pkg::CSIO_OP_SKIP_IO_ZERO;
  assign flag_io = OP_VALID && OP_IO == 6'h3F && (OP_CODE == csio_pkg::CSIO_OP_IN || OP_CODE == csio_pkg::CSIO_OP_OUT);

  // Return with no pending request, so interrupt clear cannot win
  sequence s_ret;
    OP_VALID && OP_CODE == csio_pkg::CSIO_OP_RETURN_HANDLER ##1 !IRQ_REQ;
  endsequence
  sequence s_set;
    OP_VALID && OP_CODE == csio_pkg::CSIO_OP_IO_BIT_SET && OP_IO <= 6'h1F ##1 IO_RD;
  endsequence

  a_flags_reset: assert property ($fell(SRST) |-> FLAGS == 8'h00 && !IO_WR && !IRQ_TAKEN)
    else $error("flags not clear after reset");
  a_sign_xor: assert property (FLAGS[4] == (FLAGS[2] ^ FLAGS[3]))
    else $error("sign flag differs from N xor V");
  a_irq_gate: assert property (IRQ_TAKEN |-> $past(IRQ_REQ) && $past(FLAGS[7]))
    else $error("interrupt taken while disabled");
  a_irq_clear: assert property (IRQ_REQ && FLAGS[7] |=> IRQ_TAKEN && !FLAGS[7])
    else $error("interrupt not taken or enable not cleared");
  a_ret_sets: assert property (s_ret |=> FLAGS[7])
    else $error("return did not set enable");
  a_alu_one_cycle: assert property (OP_VALID && OP_CODE == csio_pkg::CSIO_OP_ADD |-> ##2 RESULT_VALID)
    else $error("add result late");
  a_bit_range: assert property (bit_op && OP_IO > 6'h1F |-> ##1 !IO_RD ##1 (!IO_WR && !SKIP))
    else $error("bit op acted above bit space");
  a_rmw_whole: assert property (s_set |=> IO_WR && IO_WADDR == $past(IO_ADDR)
    && IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(OP_BIT, 2))))
    else $error("bit set write back wrong");
  a_flags_local: assert property (flag_io |-> ##1 !IO_RD ##1 !IO_WR)
    else $error("flag location went outside");
endmodule

`default_nettype wire

// ### tb/csio_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module csio_core_tb;
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  logic OP_VALID = 1'b0;
  logic [4:0] OP_CODE = 5'h00;
  logic [4:0] OP_DST = 5'h00;
  logic [4:0] OP_SRC = 5'h00;
  logic [7:0] OP_IMM = 8'h00;
  logic [5:0] OP_IO = 6'h00;
  logic [2:0] OP_BIT = 3'h0;
  logic IRQ_REQ = 1'b0;
  logic [7:0] IO_RDATA, FLAGS, RESULT, IO_WDATA;
  logic RESULT_VALID, SKIP, IRQ_TAKEN, IO_RD, IO_WR;
  logic [5:0] IO_ADDR, IO_WADDR;
  logic [7:0] iom [64];
  int fail_count = 0;
  int check_count = 0;
  int skip_n = 0;
  int iowr_n = 0;
  int irq_n = 0;

  // Outside I/O space, read combinationally as the core expects
  assign IO_RDATA = iom[IO_ADDR];

  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end

  csio_core u_dut (.REF_CLK(REF_CLK), .SRST(SRST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_DST(OP_DST), .OP_SRC(OP_SRC), .OP_IMM(OP_IMM), .OP_IO(OP_IO), .OP_BIT(OP_BIT),
    .IRQ_REQ(IRQ_REQ), .IO_RDATA(IO_RDATA), .FLAGS(FLAGS), .RESULT(RESULT),
    .RESULT_VALID(RESULT_VALID), .SKIP(SKIP), .IRQ_TAKEN(IRQ_TAKEN), .IO_ADDR(IO_ADDR),
    .IO_RD(IO_RD), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR));

  always @(posedge REF_CLK) begin
    if (IO_WR === 1'b1) begin
      iom[IO_WADDR] <= IO_WDATA;
      iowr_n++;
    end
    if (SKIP === 1'b1) skip_n++;
    if (IRQ_TAKEN === 1'b1) irq_n++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  // One op, then an idle cycle so its results have landed on return
  task automatic x(input logic [4:0] c, input logic [4:0] d, input logic [4:0] s,
    input logic [7:0] i, input logic [5:0] io, input logic [2:0] b);
    OP_VALID = 1'b1;
    OP_CODE = c;
    OP_DST = d;
    OP_SRC = s;
    OP_IMM = i;
    OP_IO = io;
    OP_BIT = b;
    cyc(1);
    OP_VALID = 1'b0;
    cyc(1);
  endtask

  task automatic ld(input logic [4:0] d, input logic [7:0] i);
    x(csio_pkg::CSIO_OP_LDI, d, 5'h00, i, 6'h00, 3'h0);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end

  initial begin
    foreach (iom[k]) iom[k] = 8'h00;
    repeat (6) @(posedge REF_CLK);
    #1;
    SRST = 1'b0;
    chk(FLAGS, 8'h00);
    chk({4'h0, IO_RD, IO_WR, SKIP, IRQ_TAKEN}, 8'h00);
    ld(5'h01, 8'h0F);
    ld(5'h02, 8'h01);
    x(csio_pkg::CSIO_OP_ADD, 5'h01, 5'h02, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h10);
    chk(FLAGS, 8'h20);
    ld(5'h03, 8'h7F);
    ld(5'h04, 8'h01);
    x(csio_pkg::CSIO_OP_ADD, 5'h03, 5'h04, 8'h00, 6'h00, 3'h0);
    chk(FLAGS, 8'h2C);
    ld(5'h05, 8'h80);
    x(csio_pkg::CSIO_OP_ADD, 5'h05, 5'h05, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h00);
    chk(FLAGS, 8'h1B);
    x(csio_pkg::CSIO_OP_AND, 5'h03, 5'h03, 8'h00, 6'h00, 3'h0);
    chk(FLAGS, 8'h15);
    x(csio_pkg::CSIO_OP_BIT_STORE, 5'h03, 5'h00, 8'h00, 6'h00, 3'h7);
    chk(FLAGS, 8'h55);
    ld(5'h00, 8'h00);
    x(csio_pkg::CSIO_OP_BIT_LOAD, 5'h00, 5'h00, 8'h00, 6'h00, 3'h2);
    chk(RESULT, 8'h04);
    // Outside writes go only to mapped locations with every bit in use
    ld(5'h1F, 8'hA5);
    x(csio_pkg::CSIO_OP_OUT, 5'h1F, 5'h00, 8'h00, 6'h17, 3'h0);
    x(csio_pkg::CSIO_OP_IN, 5'h08, 5'h00, 8'h00, 6'h17, 3'h0);
    chk(RESULT, 8'hA5);
    ld(5'h06, 8'h83);
    x(csio_pkg::CSIO_OP_OUT, 5'h06, 5'h00, 8'h00, 6'h3F, 3'h0);
    chk(FLAGS, 8'h83);
    x(csio_pkg::CSIO_OP_IN, 5'h09, 5'h00, 8'h00, 6'h3F, 3'h0);
    chk(RESULT, 8'h83);
    chk(8'(iowr_n), 8'h01);
    // Request held high: only the first edge may take it
    IRQ_REQ = 1'b1;
    cyc(4);
    chk(FLAGS, 8'h03);
    chk(8'(irq_n), 8'h01);
    IRQ_REQ = 1'b0;
    x(csio_pkg::CSIO_OP_RETURN_HANDLER, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0);
    chk(FLAGS, 8'h83);
    ld(5'h0A, 8'h81);
    x(csio_pkg::CSIO_OP_OUT, 5'h0A, 5'h00, 8'h00, 6'h18, 3'h0);
    x(csio_pkg::CSIO_OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h18, 3'h1);
    cyc(1);
    chk(iom[24], 8'h83);
    x(csio_pkg::CSIO_OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h00, 6'h18, 3'h0);
    cyc(1);
    chk(iom[24], 8'h82);
    x(csio_pkg::CSIO_OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h21, 3'h0);
    cyc(1);
    chk(8'(iowr_n), 8'h04);
    x(csio_pkg::CSIO_OP_SKIP_IO_ONE, 5'h00, 5'h00, 8'h00, 6'h18, 3'h7);
    x(csio_pkg::CSIO_OP_SKIP_IO_ZERO, 5'h00, 5'h00, 8'h00, 6'h18, 3'h7);
    x(csio_pkg::CSIO_OP_SKIP_IO_ZERO, 5'h00, 5'h00, 8'h00, 6'h21, 3'h0);
    x(csio_pkg::CSIO_OP_SKIP_IO_ZERO, 5'h00, 5'h00, 8'h00, 6'h18, 3'h0);
    cyc(1);
    chk(8'(skip_n), 8'h02);
    x(csio_pkg::CSIO_OP_SUB, 5'h02, 5'h04, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h00);
    chk(FLAGS, 8'h82);
    x(csio_pkg::CSIO_OP_SUB, 5'h02, 5'h04, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'hFF);
    chk(FLAGS, 8'hB5);
    // Zero result after a nonzero step must leave zero clear
    x(csio_pkg::CSIO_OP_SBC, 5'h04, 5'h05, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h00);
    chk(FLAGS, 8'h80);
    x(csio_pkg::CSIO_OP_ADD, 5'h03, 5'h03, 8'h00, 6'h00, 3'h0);
    chk(FLAGS, 8'h9B);
    x(csio_pkg::CSIO_OP_ADC, 5'h01, 5'h02, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h10);
    chk(FLAGS, 8'hA1);
    x(csio_pkg::CSIO_OP_EOR, 5'h02, 5'h02, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h00);
    chk(FLAGS, 8'hA3);
    x(csio_pkg::CSIO_OP_OR, 5'h01, 5'h0A, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h91);
    chk(FLAGS, 8'hB5);
    x(csio_pkg::CSIO_OP_MOV, 5'h07, 5'h0A, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h81);
    chk(FLAGS, 8'hB5);
    // Idle and undefined codes must leave result and flags alone
    x(csio_pkg::CSIO_OP_NOP, 5'h07, 5'h01, 8'h00, 6'h00, 3'h0);
    x(5'h1F, 5'h07, 5'h01, 8'h00, 6'h00, 3'h0);
    chk(RESULT, 8'h81);
    chk(FLAGS, 8'hB5);
    print_verdict();
  end
endmodule

bind csio_core csio_checker u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .OP_IO(OP_IO), .OP_BIT(OP_BIT), .IRQ_REQ(IRQ_REQ), .IO_RDATA(IO_RDATA),
  .FLAGS(FLAGS), .RESULT_VALID(RESULT_VALID), .SKIP(SKIP), .IRQ_TAKEN(IRQ_TAKEN),
  .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR));

`default_nettype wire
